// >>> verilog/integ_ctrl.sv
// Local design decisions: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// - Hold freezes shown and reported value; accumulation continues underneath.
// - Sample indicator keeps blinking during hold.
// - Start under hold keeps frozen value; release or update shows live total.
// - Stop under hold; release or update shows total captured at stop.
// - Power failure while integrating keeps value and time in backup.
// - After such failure stay stopped, refuse start until reset.
// - On power return show retained value and time.
// - Measuring method, averaging, scaling, line filter change only when stopped.
// - Range changes, auto and stepping, only when stopped.
// - Hold and update always accepted; rate change only when stopped.
// - Timer preset edit refused unless stopped; display always allowed.
// - Blocked key shows numeric error code on fourth display.
// - Reset refused while running; allowed paused or stopped.
// - Start with auto ranging switches to manual, range unchanged.
// - Stop pauses holding time and value; reset clears both.
module integ_ctrl
    import integ_pkg::*;
#(
    parameter int BLINK_HALF = BLINK_CYCLES
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // Measurement side
    input  wire logic        acc_tick_i,
    input  wire logic [31:0] acc_delta_i,
    input  wire logic        sec_tick_i,
    input  wire logic        power_fail_i,
    // Indicators
    output logic             sample_led_o,
    output logic             irq_o
);
    integ_state_t state_ff;
    integ_snap_t  live_ff;
    integ_snap_t  shown_ff;
    integ_snap_t  stop_snap_ff;
    integ_snap_t  backup_ff;
    logic         hold_ff;
    logic         locked_ff;
    logic         backed_ff;
    logic         stopped_under_hold_ff;
    logic [7:0]   err_ff;
    logic [7:0]   setup_ff;
    logic [15:0]  preset_ff;
    logic [IRQ_W-1:0] irq_st_ff;
    logic [IRQ_W-1:0] irq_msk_ff;
    logic         blink;

    logic         wr;
    logic         key_wr;
    logic [4:0]   key;
    logic         accept;
    logic [7:0]   gate_err;
    logic         do_start;
    logic         do_stop;
    logic         do_reset;
    logic         refresh;

    assign wr     = cyc_i && stb_i && we_i && !ack_o;
    assign key_wr = wr && adr_i == KEY_OFS && sel_i[0];
    assign key    = dat_i[4:0];

    key_gate u_gate (
        .key_i    (key),
        .state_i  (state_ff),
        .locked_i (locked_ff),
        .accept_o (accept),
        .err_o    (gate_err)
    );

    blink_div #(.HALF(BLINK_HALF)) u_blink (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .blink_o (blink)
    );

    // The indicator is never gated by hold since sampling does not pause.
    assign sample_led_o = blink;

    assign do_start = key_wr && key == KEY_START && accept;
    assign do_stop  = key_wr && key == KEY_STOP && accept;
    assign do_reset = key_wr && key == KEY_RESET && accept;
    assign refresh  = key_wr && ((key == KEY_HOLD && hold_ff) || key == KEY_UPDATE);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
        end
    end

    // Integration state machine.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= ST_STOPPED;
        end else if (power_fail_i) begin
            state_ff <= ST_STOPPED;
        end else begin
            case (state_ff)
                ST_STOPPED: if (do_start) state_ff <= ST_RUNNING;
                ST_RUNNING: if (do_stop) state_ff <= ST_PAUSED;
                ST_PAUSED: begin
                    if (do_start) begin
                        state_ff <= ST_RUNNING;
                    end else if (do_reset) begin
                        state_ff <= ST_STOPPED;
                    end
                end
                default: state_ff <= ST_STOPPED;
            endcase
        end
    end

    // Live accumulation ignores hold entirely.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            live_ff <= '0;
        end else if (do_reset) begin
            live_ff <= '0;
        end else if (state_ff == ST_RUNNING && !power_fail_i) begin
            if (acc_tick_i) begin
                live_ff.value <= live_ff.value + acc_delta_i;
            end
            if (sec_tick_i) begin
                live_ff.seconds <= live_ff.seconds + 32'h1;
            end
        end
    end

    // Power failure backup and lockout.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            backup_ff <= '0;
            backed_ff <= 1'b0;
            locked_ff <= 1'b0;
        end else if (power_fail_i && state_ff != ST_STOPPED) begin
            backup_ff <= live_ff;
            backed_ff <= 1'b1;
            locked_ff <= 1'b1;
        end else if (locked_ff && key_wr && key == KEY_RESET) begin
            // The backup is spent once the reset clears it, so the flag must not outlive the lock.
            locked_ff <= 1'b0;
            backed_ff <= 1'b0;
            backup_ff <= '0;
        end
    end

    // Snapshot at the stop request, used when hold is later released.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stop_snap_ff          <= '0;
            stopped_under_hold_ff <= 1'b0;
        end else if (do_stop) begin
            stop_snap_ff          <= live_ff;
            stopped_under_hold_ff <= hold_ff;
        end else if (do_start || do_reset) begin
            stopped_under_hold_ff <= 1'b0;
        end
    end

    // Hold toggles; hold and update are never blocked.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_ff <= 1'b0;
        end else if (key_wr && key == KEY_HOLD) begin
            hold_ff <= ~hold_ff;
        end
    end

    // Shown value: frozen during hold, refreshed on release or update.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shown_ff <= '0;
        end else if (locked_ff) begin
            shown_ff <= backup_ff;
        end else if (do_reset) begin
            shown_ff <= '0;
        end else if (refresh) begin
            shown_ff <= stopped_under_hold_ff ? stop_snap_ff : live_ff;
        end else if (!hold_ff) begin
            shown_ff <= live_ff;
        end
    end

    // Settings and range control.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            setup_ff  <= SETUP_RST;
            preset_ff <= PRESET_RST;
        end else begin
            if (do_start && state_ff == ST_STOPPED) begin
                setup_ff[SETUP_V_AUTO_BIT] <= 1'b0;
                setup_ff[SETUP_I_AUTO_BIT] <= 1'b0;
            end else if (wr && adr_i == SETUP_OFS && sel_i[0] && state_ff == ST_STOPPED) begin
                setup_ff <= dat_i[7:0];
            end
            if (wr && adr_i == PRESET_OFS && state_ff == ST_STOPPED) begin
                preset_ff <= dat_i[15:0];
            end
        end
    end

    // Error code for the fourth display.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            err_ff <= ERR_NONE;
        end else if (key_wr) begin
            err_ff <= accept ? ERR_NONE : gate_err;
        end
    end

    // Interrupt status: set wins over write-one clear.
    logic [IRQ_W-1:0] irq_set;
    always_comb begin
        irq_set              = '0;
        irq_set[IRQ_ERR_BIT] = key_wr && !accept;
        irq_set[IRQ_STATE_BIT] = do_start || do_stop || do_reset || power_fail_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_st_ff  <= '0;
            irq_msk_ff <= '0;
        end else begin
            if (wr && adr_i == IRQ_ST_OFS && sel_i[0]) begin
                irq_st_ff <= (irq_st_ff & ~dat_i[IRQ_W-1:0]) | irq_set;
            end else begin
                irq_st_ff <= irq_st_ff | irq_set;
            end
            if (wr && adr_i == IRQ_MSK_OFS && sel_i[0]) begin
                irq_msk_ff <= dat_i[IRQ_W-1:0];
            end
        end
    end

    assign irq_o = |(irq_st_ff & irq_msk_ff);

    // Read data is registered together with the ack.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0;
        end else if (cyc_i && stb_i && !we_i && !ack_o) begin
            case (adr_i)
                CTRL_OFS:    dat_o <= {31'h0, blink};
                STATUS_OFS:  dat_o <= {26'h0, backed_ff, locked_ff, hold_ff,
                                       stopped_under_hold_ff, state_ff};
                IRQ_ST_OFS:  dat_o <= {30'h0, irq_st_ff};
                IRQ_MSK_OFS: dat_o <= {30'h0, irq_msk_ff};
                SHOWN_OFS:   dat_o <= shown_ff.value;
                TIME_OFS:    dat_o <= shown_ff.seconds;
                ERR_OFS:     dat_o <= {24'h0, err_ff};
                PRESET_OFS:  dat_o <= {16'h0, preset_ff};
                SETUP_OFS:   dat_o <= {24'h0, setup_ff};
                default:     dat_o <= 32'h0;
            endcase
        end
    end

    hold_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
        hold_ff && !refresh && !locked_ff && !do_reset && $past(hold_ff) |=> $stable(shown_ff))
        else $error("shown value moved during hold");
    run_accum_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_ff == ST_RUNNING && acc_tick_i && !power_fail_i && !do_reset && !backed_ff
        |=> live_ff.value == $past(live_ff.value) + $past(acc_delta_i))
        else $error("accumulation lost");
    stop_show_a: assert property (@(posedge clk_i) disable iff (rst_i)
        refresh && stopped_under_hold_ff && !locked_ff && !do_reset |=> shown_ff == $past(stop_snap_ff))
        else $error("stop snapshot not shown");
    lock_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
        locked_ff && state_ff == ST_STOPPED && key_wr && key == KEY_START |=> state_ff == ST_STOPPED)
        else $error("start accepted while locked");
    no_reset_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_ff == ST_RUNNING && key_wr && key == KEY_RESET && !power_fail_i |=> state_ff != ST_STOPPED)
        else $error("reset honoured while running");
    blocked_err_a: assert property (@(posedge clk_i) disable iff (rst_i)
        key_wr && key == KEY_RATE && state_ff != ST_STOPPED |=> err_ff == ERR_SETTING)
        else $error("missing error code");
    auto_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        do_start && state_ff == ST_STOPPED |=> setup_ff[SETUP_V_AUTO_BIT] == 1'b0)
        else $error("auto range kept at start");
    backup_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        power_fail_i && state_ff != ST_STOPPED |=> backup_ff == $past(live_ff))
        else $error("backup not taken");
endmodule

// >>> inc/integ_pkg.sv
package integ_pkg;

    // Register byte offsets on the Wishbone bus.
    localparam logic [7:0] CTRL_OFS    = 8'h00;
    localparam logic [7:0] KEY_OFS     = 8'h04;
    localparam logic [7:0] STATUS_OFS  = 8'h08;
    localparam logic [7:0] IRQ_ST_OFS  = 8'h0C;
    localparam logic [7:0] IRQ_MSK_OFS = 8'h10;
    localparam logic [7:0] SHOWN_OFS   = 8'h14;
    localparam logic [7:0] TIME_OFS    = 8'h18;
    localparam logic [7:0] ERR_OFS     = 8'h1C;
    localparam logic [7:0] PRESET_OFS  = 8'h20;
    localparam logic [7:0] SETUP_OFS   = 8'h24;

    // Key command codes written to the key register.
    localparam logic [4:0] KEY_START      = 5'h01;
    localparam logic [4:0] KEY_STOP       = 5'h02;
    localparam logic [4:0] KEY_RESET      = 5'h03;
    localparam logic [4:0] KEY_HOLD       = 5'h04;
    localparam logic [4:0] KEY_UPDATE     = 5'h05;
    localparam logic [4:0] KEY_RATE       = 5'h06;
    localparam logic [4:0] KEY_MEAS_MODE  = 5'h07;
    localparam logic [4:0] KEY_AVERAGING_SELECT = 5'h08;
    localparam logic [4:0] KEY_SCALING    = 5'h09;
    localparam logic [4:0] KEY_LINE_FILT  = 5'h0A;
    localparam logic [4:0] KEY_V_AUTO     = 5'h0B;
    localparam logic [4:0] KEY_V_STEP     = 5'h0C;
    localparam logic [4:0] KEY_I_AUTO     = 5'h0D;
    localparam logic [4:0] KEY_I_STEP     = 5'h0E;
    localparam logic [4:0] KEY_TIMER_EDIT = 5'h0F;
    localparam logic [4:0] KEY_TIMER_SHOW = 5'h10;

    // Error codes shown on the fourth display.
    localparam logic [7:0] ERR_NONE       = 8'h00;
    localparam logic [7:0] ERR_SETTING    = 8'd13;
    localparam logic [7:0] ERR_INTEG_KEY  = 8'd42;
    localparam logic [7:0] ERR_LOCKED     = 8'd44;

    // Field positions.
    localparam int SETUP_V_AUTO_BIT = 0;
    localparam int SETUP_I_AUTO_BIT = 1;
    localparam int CTRL_SAMPLE_BIT  = 0;
    localparam int IRQ_ERR_BIT      = 0;
    localparam int IRQ_STATE_BIT    = 1;
    localparam int IRQ_W            = 2;

    // Reset values.
    localparam logic [7:0]  SETUP_RST  = 8'h03;
    localparam logic [15:0] PRESET_RST = 16'h0000;

    // Sampling indicator blink half period.
    localparam int BLINK_MS     = 250;
    localparam int CLK_MHZ      = 100;
    localparam int BLINK_CYCLES = BLINK_MS * 1000 * CLK_MHZ;

    typedef enum logic [1:0] {
        ST_STOPPED,
        ST_RUNNING,
        ST_PAUSED
    } integ_state_t;

    typedef struct packed {
        logic [31:0] value;
        logic [31:0] seconds;
    } integ_snap_t;

endpackage

// >>> verilog/key_gate.sv
`timescale 1ns/1ps
module key_gate
    import integ_pkg::*;
(
    // Request
    input  wire logic [4:0]   key_i,
    input  integ_state_t      state_i,
    input  wire logic         locked_i,
    // Verdict
    output logic              accept_o,
    output logic [7:0]        err_o
);
    always_comb begin
        accept_o = 1'b1;
        err_o    = ERR_NONE;
        case (key_i)
            KEY_START: begin
                if (locked_i) begin
                    accept_o = 1'b0;
                    err_o    = ERR_LOCKED;
                end else if (state_i == ST_RUNNING) begin
                    accept_o = 1'b0;
                    err_o    = ERR_INTEG_KEY;
                end
            end
            KEY_STOP: begin
                if (state_i != ST_RUNNING) begin
                    accept_o = 1'b0;
                    err_o    = ERR_INTEG_KEY;
                end
            end
            KEY_RESET: begin
                if (state_i == ST_RUNNING) begin
                    accept_o = 1'b0;
                    err_o    = ERR_INTEG_KEY;
                end
            end
            KEY_HOLD, KEY_UPDATE, KEY_TIMER_SHOW: begin
                accept_o = 1'b1;
            end
            KEY_RATE, KEY_MEAS_MODE, KEY_AVERAGING_SELECT, KEY_SCALING, KEY_LINE_FILT,
            KEY_V_AUTO, KEY_V_STEP, KEY_I_AUTO, KEY_I_STEP, KEY_TIMER_EDIT: begin
                if (state_i != ST_STOPPED) begin
                    accept_o = 1'b0;
                    err_o    = ERR_SETTING;
                end
            end
            default: begin
                accept_o = 1'b0;
                err_o    = ERR_NONE;
            end
        endcase
    end
endmodule

// >>> verilog/blink_div.sv
`timescale 1ns/1ps
module blink_div #(
    parameter int HALF = 25000000
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Indicator
    output logic      blink_o
);
    logic [31:0] cnt_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff  <= 32'h0;
            blink_o <= 1'b0;
        end else if (cnt_ff >= 32'(HALF - 1)) begin
            cnt_ff  <= 32'h0;
            blink_o <= ~blink_o;
        end else begin
            cnt_ff <= cnt_ff + 32'h1;
        end
    end
endmodule

// >>> tb/meas_source.sv
`timescale 1ns/1ps
module meas_source (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Command
    input  wire logic        go_i,
    input  wire logic [7:0]  count_i,
    input  wire logic [31:0] delta_i,
    output logic             busy_o,
    // Measurement side
    output logic             acc_tick_o,
    output logic [31:0]      acc_delta_o,
    output logic             sec_tick_o
);
    logic [7:0] left_ff;
    logic       phase_ff;

    // Ticks come every other cycle, so an accumulator that also counts idle cycles is caught.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            left_ff  <= 8'h00;
            phase_ff <= 1'b0;
        end else if (go_i) begin
            left_ff  <= count_i;
            phase_ff <= 1'b0;
        end else if (left_ff != 8'h00) begin
            phase_ff <= ~phase_ff;
            if (phase_ff) begin
                left_ff <= left_ff - 8'h01;
            end
        end
    end

    assign busy_o      = (left_ff != 8'h00);
    assign acc_tick_o  = busy_o && phase_ff;
    assign sec_tick_o  = acc_tick_o;
    // Outside a tick the delta is inverted, so a design that adds it untimed shows a wrong sum.
    assign acc_delta_o = acc_tick_o ? delta_i : ~delta_i;
endmodule

// >>> tb/integrator_key_lockout_control_test.sv
`timescale 1ns/1ps
module integrator_key_lockout_control_test
    import integ_pkg::*;
;
    localparam logic [31:0] DELTA = 32'h0000_0103;

    logic        clk_i;
    logic        rst_i;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat_w;
    logic [31:0] dat_r;
    logic        ack;
    logic        acc_tick;
    logic [31:0] acc_delta;
    logic        sec_tick;
    logic        power_fail;
    logic        sample_led;
    logic        irq;
    logic        go;
    logic [7:0]  cnt;
    logic        busy;
    logic [31:0] q;
    logic        led_was;
    int          err_count;
    int          num_checks;

    integ_ctrl #(.BLINK_HALF(4)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
        .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .acc_tick_i(acc_tick), .acc_delta_i(acc_delta),
        .sec_tick_i(sec_tick), .power_fail_i(power_fail), .sample_led_o(sample_led), .irq_o(irq)
    );

    meas_source i_src (
        .clk_i(clk_i), .rst_i(rst_i), .go_i(go), .count_i(cnt), .delta_i(DELTA), .busy_o(busy),
        .acc_tick_o(acc_tick), .acc_delta_o(acc_delta), .sec_tick_o(sec_tick)
    );

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One classic cycle; the request stands until ack is sampled high.
    task automatic wb_cycle(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= a;
        sel   <= 4'hF;
        dat_w <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        end
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        wb_cycle(a, 1'b0, 32'h0000_0000);
        check(q & m, exp);
    endtask

    task automatic key(input logic [4:0] k);
        wb_cycle(KEY_OFS, 1'b1, {27'h0, k});
    endtask

    task automatic ticks(input logic [7:0] n);
        int t;
        t = 0;
        @(posedge clk_i);
        go  <= 1'b1;
        cnt <= n;
        @(posedge clk_i);
        go <= 1'b0;
        @(posedge clk_i);
        while (busy === 1'b1 && t < 1000) begin
            @(posedge clk_i);
            t++;
        end
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        finish_test();
    end

    initial begin
        err_count  = 0;
        num_checks = 0;
        rst_i = 1'b1;
        {cyc, stb, we, go, power_fail} = 5'h00;
        adr   = 8'h00;
        sel   = 4'h0;
        dat_w = 32'h0000_0000;
        cnt   = 8'h00;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(STATUS_OFS, 32'h3F, 32'h00);
        rd_chk(SETUP_OFS, 32'hFF, {24'h0, SETUP_RST});
        rd_chk(8'h40, 32'hFFFF_FFFF, 32'h0);
        check({31'h0, irq}, 32'h0);
        key(KEY_STOP);
        rd_chk(ERR_OFS, 32'hFF, {24'h0, ERR_INTEG_KEY});
        key(KEY_HOLD);
        key(KEY_START);
        rd_chk(STATUS_OFS, 32'h0B, 32'h09);
        rd_chk(SETUP_OFS, 32'h03, 32'h00);
        ticks(8'h05);
        rd_chk(SHOWN_OFS, 32'hFFFF_FFFF, 32'h0);
        led_was = sample_led;
        repeat (4) @(posedge clk_i);
        check({31'h0, sample_led}, {31'h0, ~led_was});
        key(KEY_UPDATE);
        rd_chk(SHOWN_OFS, 32'hFFFF_FFFF, DELTA * 5);
        rd_chk(ERR_OFS, 32'hFF, {24'h0, ERR_NONE});
        ticks(8'h04);
        rd_chk(SHOWN_OFS, 32'hFFFF_FFFF, DELTA * 5);
        for (int k = KEY_RATE; k <= KEY_TIMER_EDIT; k++) begin
            key(k[4:0]);
            rd_chk(ERR_OFS, 32'hFF, {24'h0, ERR_SETTING});
        end
        key(KEY_TIMER_SHOW);
        rd_chk(ERR_OFS, 32'hFF, {24'h0, ERR_NONE});
        wb_cycle(SETUP_OFS, 1'b1, 32'h3);
        rd_chk(SETUP_OFS, 32'h03, 32'h00);
        wb_cycle(PRESET_OFS, 1'b1, 32'h1234);
        rd_chk(PRESET_OFS, 32'hFFFF, {16'h0, PRESET_RST});
        key(KEY_RESET);
        rd_chk(ERR_OFS, 32'hFF, {24'h0, ERR_INTEG_KEY});
        key(KEY_START);
        rd_chk(ERR_OFS, 32'hFF, {24'h0, ERR_INTEG_KEY});
        key(KEY_STOP);
        rd_chk(STATUS_OFS, 32'h0B, 32'h0A);
        ticks(8'h03);
        key(KEY_HOLD);
        rd_chk(SHOWN_OFS, 32'hFFFF_FFFF, DELTA * 9);
        rd_chk(TIME_OFS, 32'hFFFF_FFFF, 32'd9);
        key(KEY_AVERAGING_SELECT);
        rd_chk(ERR_OFS, 32'hFF, {24'h0, ERR_SETTING});
        key(KEY_START);
        ticks(8'h02);
        rd_chk(SHOWN_OFS, 32'hFFFF_FFFF, DELTA * 11);
        key(KEY_STOP);
        key(KEY_RESET);
        rd_chk(STATUS_OFS, 32'h3F, 32'h00);
        rd_chk(SHOWN_OFS, 32'hFFFF_FFFF, 32'h0);
        rd_chk(TIME_OFS, 32'hFFFF_FFFF, 32'h0);
        wb_cycle(PRESET_OFS, 1'b1, 32'h1234);
        rd_chk(PRESET_OFS, 32'hFFFF, 32'h1234);
        wb_cycle(SETUP_OFS, 1'b1, 32'h2);
        rd_chk(SETUP_OFS, 32'h03, 32'h02);
        rd_chk(IRQ_ST_OFS, 32'h1, 32'h1);
        wb_cycle(IRQ_MSK_OFS, 1'b1, 32'h1);
        check({31'h0, irq}, 32'h1);
        wb_cycle(IRQ_MSK_OFS, 1'b1, 32'h0);
        check({31'h0, irq}, 32'h0);
        wb_cycle(IRQ_ST_OFS, 1'b1, 32'h3);
        rd_chk(IRQ_ST_OFS, 32'h3, 32'h0);
        key(KEY_START);
        ticks(8'h03);
        power_fail <= 1'b1;
        repeat (2) @(posedge clk_i);
        power_fail <= 1'b0;
        repeat (2) @(posedge clk_i);
        rd_chk(STATUS_OFS, 32'h13, 32'h10);
        rd_chk(SHOWN_OFS, 32'hFFFF_FFFF, DELTA * 3);
        rd_chk(TIME_OFS, 32'hFFFF_FFFF, 32'd3);
        key(KEY_START);
        rd_chk(ERR_OFS, 32'hFF, {24'h0, ERR_LOCKED});
        rd_chk(STATUS_OFS, 32'h03, 32'h00);
        key(KEY_RESET);
        rd_chk(STATUS_OFS, 32'h13, 32'h00);
        key(KEY_START);
        rd_chk(STATUS_OFS, 32'h03, 32'h01);
        wb_cycle(IRQ_MSK_OFS, 1'b1, 32'h2);
        check({31'h0, irq}, 32'h1);
        finish_test();
    end
endmodule
